// File: verilog/dtc_regs.svh
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

`define DTC_ADDR_CFG 4'h0
`define DTC_ADDR_TIMING 4'h4
`define DTC_ADDR_IRQ_STATUS 4'h8
`define DTC_ADDR_IRQ_MASK 4'hc

`define DTC_BIT_PENDING 31
`define DTC_BIT_BLINK_RATE 16
`define DTC_BIT_PIXEL_DOUBLE 15
`define DTC_BIT_PLANAR 13
`define DTC_BIT_CENTER 12
`define DTC_BIT_PANEL_VSP 11
`define DTC_BIT_PANEL_HSP 10
`define DTC_BIT_CRT_VSP 9
`define DTC_BIT_CRT_HSP 8
`define DTC_BIT_BLINK_ON 7
`define DTC_BIT_VIRQ_EN 6
`define DTC_BIT_TIMING_GEN_ON 5
`define DTC_BIT_DDC_CLK 4
`define DTC_BIT_BLANK_EN 3
`define DTC_BIT_HSYNC_EN 2
`define DTC_BIT_VSYNC_EN 1

`define DTC_CFG_RESET 32'h0000_0000
`define DTC_CFG_WMASK 32'h0001_bffe
`define DTC_TIMING_RESET 32'h0000_0000
`define DTC_IRQ_VSYNC 0
`define DTC_IRQ_FRAME 1

`endif

// File: verilog/dtc_pkg.sv
package dtc_pkg;
    typedef enum logic [3:0] {
        DTC_ACTIVE = 4'h1,
        DTC_BORDER = 4'h2,
        DTC_SYNC = 4'h4,
        DTC_BLANK = 4'h8
    } dtc_region_e;
    typedef logic [11:0] dtc_count_t;
endpackage : dtc_pkg

// File: verilog/dtc_axis.sv
`timescale 1ns/1ps
`include "dtc_regs.svh"
module dtc_axis
    import dtc_pkg::*;
#(
    parameter int WIDTH = 12
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic step,
    input wire logic [WIDTH-1:0] active_len,
    input wire logic [WIDTH-1:0] border_len,
    input wire logic [WIDTH-1:0] sync_len,
    input wire logic [WIDTH-1:0] blank_len,
    output dtc_region_e region,
    output logic wrap
);
    initial begin
        if (WIDTH < 2 || WIDTH > 16) begin
            $error("dtc_axis width out of range");
        end
    end

    logic [WIDTH-1:0] count;
    dtc_region_e next_region;
    logic [WIDTH-1:0] cur_len;
    wire last_step = step && (count >= cur_len);

    always_comb begin
        case (region)
            DTC_ACTIVE: cur_len = active_len;
            DTC_BORDER: cur_len = border_len;
            DTC_SYNC: cur_len = sync_len;
            DTC_BLANK: cur_len = blank_len;
            default: cur_len = active_len;
        endcase
    end

    always_comb begin
        case (region)
            DTC_ACTIVE: next_region = DTC_BORDER;
            DTC_BORDER: next_region = DTC_SYNC;
            DTC_SYNC: next_region = DTC_BLANK;
            DTC_BLANK: next_region = DTC_ACTIVE;
            default: next_region = DTC_ACTIVE;
        endcase
    end

    assign wrap = last_step && (region == DTC_BLANK);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            region <= DTC_ACTIVE;
            count <= '0;
        end else if (!run) begin
            region <= DTC_ACTIVE;
            count <= '0;
        end else if (last_step) begin
            region <= next_region;
            count <= '0;
        end else if (step) begin
            count <= count + 1'b1;
        end
    end
endmodule : dtc_axis

// File: verilog/dtc_blink.sv
`timescale 1ns/1ps
module dtc_blink
    import dtc_pkg::*;
#(
    parameter int FRAME_BITS = 6
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic frame_tick,
    input wire logic rate_slow,
    input wire logic blink_on,
    output logic cursor_show,
    output logic text_show
);
    initial begin
        if (FRAME_BITS < 6) begin
            $error("dtc_blink needs at least six frame bits");
        end
    end

    logic [FRAME_BITS-1:0] frames;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frames <= '0;
        end else if (!run) begin
            frames <= '0;
        end else if (frame_tick) begin
            frames <= frames + 1'b1;
        end
    end

    // Rate and enable select the visible phase.
    // Tap 3 gives 16 frames with 8 shown, tap 4 gives 32 with 16 shown.
    wire cur_phase = rate_slow ? frames[4] : frames[3];
    // Tap 4 gives 32 frames with 16 shown, tap 5 gives 64 with 32 shown.
    wire txt_phase = rate_slow ? frames[5] : frames[4];
    assign cursor_show = !blink_on || !cur_phase;
    assign text_show = !blink_on || !txt_phase;
endmodule : dtc_blink

// File: verilog/dtc_timing.sv
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "dtc_regs.svh"
// Summary of operation
// - Normal rate: cursor 16/8, text 32/16.
// - Slow rate: cursor 32/16, text 64/32.
// - Blinking only while blink enable set.
// - Pixel doubling shows each pixel twice.
// - Centering extends panel enable over border.
// - Panel vsync polarity from bit 11.
// - Panel hsync polarity from bit 10.
// - Crt_vertical_sync polarity from bit 9.
// - Crt_horizontal_sync polarity from bit 8.
// - Vertical interrupt at sync; disable clears, except when a sync start falls in the same cycle.
// - Generator off resets dot logic, allows writes.
// - DDC clock drives Crt_vertical_sync when disabled.
// - Pending vertical interrupt reads in bit 31.
// - Hsync disabled holds Crt_horizontal_sync low.
module dtc_timing
    import dtc_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int PIX_WIDTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [PIX_WIDTH-1:0] pixel_in,
    output logic pixel_fetch,
    output logic [PIX_WIDTH-1:0] pixel_out,
    output logic cursor_visible,
    output logic text_visible,
    output logic planar_vga_select,
    output logic panel_display_enable,
    output logic panel_vsync,
    output logic panel_hsync,
    output logic crt_vertical_sync,
    output logic crt_horizontal_sync,
    output logic irq
);
    initial begin
        if (WIDTH < 4 || WIDTH > 16 || PIX_WIDTH < 1) begin
            $error("dtc_timing parameters out of range");
        end
    end

    logic [31:0] cfg;
    logic [31:0] timing;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic pending;
    logic half;

    wire blink_rate_select = cfg[`DTC_BIT_BLINK_RATE];
    wire pixel_doubling = cfg[`DTC_BIT_PIXEL_DOUBLE];
    wire panel_centering = cfg[`DTC_BIT_CENTER];
    wire panel_vsync_polarity = cfg[`DTC_BIT_PANEL_VSP];
    wire panel_hsync_polarity = cfg[`DTC_BIT_PANEL_HSP];
    wire crt_vertical_sync_polarity = cfg[`DTC_BIT_CRT_VSP];
    wire crt_horizontal_sync_polarity = cfg[`DTC_BIT_CRT_HSP];
    wire blink_on = cfg[`DTC_BIT_BLINK_ON];
    wire vertical_irq_enable = cfg[`DTC_BIT_VIRQ_EN];
    wire timing_gen_on = cfg[`DTC_BIT_TIMING_GEN_ON];
    wire ddc_serial_clock_bit = cfg[`DTC_BIT_DDC_CLK];
    wire blank_enable = cfg[`DTC_BIT_BLANK_EN];
    wire hsync_output_enable = cfg[`DTC_BIT_HSYNC_EN];
    wire vsync_output_enable = cfg[`DTC_BIT_VSYNC_EN];

    wire sel_cfg = addr == `DTC_ADDR_CFG;
    wire sel_timing = addr == `DTC_ADDR_TIMING;
    wire sel_status = addr == `DTC_ADDR_IRQ_STATUS;
    wire sel_mask = addr == `DTC_ADDR_IRQ_MASK;
    wire timing_wr = wr && sel_timing && !timing_gen_on;

    // Active lengths are byte fields, the other lengths 4-bit fields; zero means one unit.
    wire [WIDTH-1:0] h_act = WIDTH'(timing[7:0]);
    wire [WIDTH-1:0] h_brd = WIDTH'(timing[7:4]);
    wire [WIDTH-1:0] h_syn = WIDTH'(timing[11:8]);
    wire [WIDTH-1:0] v_act = WIDTH'(timing[23:16]);
    wire [WIDTH-1:0] v_brd = WIDTH'(timing[19:16]);
    wire [WIDTH-1:0] v_syn = WIDTH'(timing[27:24]);
    wire [WIDTH-1:0] v_blk = WIDTH'(timing[31:28]);

    dtc_region_e h_region;
    dtc_region_e v_region;
    logic line_end;
    logic frame_end;
    logic cur_show;
    logic txt_show;

    dtc_axis #(.WIDTH(WIDTH)) u_h (
        .clk(clk),
        .nrst(nrst),
        .run(timing_gen_on),
        .step(1'b1),
        .active_len(h_act),
        .border_len(h_brd),
        .sync_len(h_syn),
        .blank_len(h_brd),
        .region(h_region),
        .wrap(line_end)
    );

    dtc_axis #(.WIDTH(WIDTH)) u_v (
        .clk(clk),
        .nrst(nrst),
        .run(timing_gen_on),
        .step(line_end),
        .active_len(v_act),
        .border_len(v_brd),
        .sync_len(v_syn),
        .blank_len(v_blk),
        .region(v_region),
        .wrap(frame_end)
    );

    wire h_sync = h_region == DTC_SYNC;
    wire v_sync = v_region == DTC_SYNC;
    wire h_act_w = h_region == DTC_ACTIVE;
    wire v_act_w = v_region == DTC_ACTIVE;
    wire h_vis = h_act_w || (h_region == DTC_BORDER);
    wire v_vis = v_act_w || (v_region == DTC_BORDER);
    logic v_sync_d;
    wire vsync_start = v_sync && !v_sync_d;

    dtc_blink u_blink (
        .clk(clk),
        .nrst(nrst),
        .run(timing_gen_on),
        .frame_tick(vsync_start),
        .rate_slow(blink_rate_select),
        .blink_on(blink_on),
        .cursor_show(cur_show),
        .text_show(txt_show)
    );

    wire next_enable = blank_enable && timing_gen_on
        && (panel_centering ? (h_vis && v_vis) : (h_act_w && v_act_w));
    wire next_fetch = timing_gen_on && h_act_w && v_act_w && (!pixel_doubling || !half);
    wire crt_v_level = vsync_output_enable
        ? ((v_sync && timing_gen_on) ^ crt_vertical_sync_polarity) : ddc_serial_clock_bit;
    wire crt_h_level = hsync_output_enable && ((h_sync && timing_gen_on) ^ crt_horizontal_sync_polarity);
    wire cfg_vertical_irq_enable_clear = wr && sel_cfg && !wdata[`DTC_BIT_VIRQ_EN];
    wire next_pending = (vertical_irq_enable && timing_gen_on && vsync_start)
        || (pending && !cfg_vertical_irq_enable_clear);
    wire [1:0] events = {frame_end, vsync_start && timing_gen_on};
    wire [1:0] next_status = events | (irq_status & {2{!(rd && sel_status)}});

    wire [31:0] cfg_view = {pending, cfg[30:0]};
    wire [31:0] next_rdata = sel_cfg ? cfg_view
        : sel_timing ? timing
        : sel_status ? {30'h0, irq_status}
        : sel_mask ? {30'h0, irq_mask} : 32'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg <= `DTC_CFG_RESET;
            timing <= `DTC_TIMING_RESET;
            irq_mask <= 2'h0;
        end else begin
            if (wr && sel_cfg) begin
                cfg <= wdata & `DTC_CFG_WMASK;
            end
            if (timing_wr) begin
                timing <= wdata;
            end
            if (wr && sel_mask) begin
                irq_mask <= wdata[1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pending <= 1'b0;
            irq_status <= 2'h0;
            irq <= 1'b0;
            rdata <= 32'h0;
            v_sync_d <= 1'b0;
            half <= 1'b0;
        end else begin
            pending <= next_pending;
            irq_status <= next_status;
            irq <= |(next_status & irq_mask);
            rdata <= rd ? next_rdata : 32'h0;
            v_sync_d <= v_sync && timing_gen_on;
            half <= (timing_gen_on && h_act_w && pixel_doubling) ? !half : 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pixel_fetch <= 1'b0;
            pixel_out <= '0;
            cursor_visible <= 1'b1;
            text_visible <= 1'b1;
            planar_vga_select <= 1'b0;
            panel_display_enable <= 1'b0;
            panel_vsync <= 1'b0;
            panel_hsync <= 1'b0;
            crt_vertical_sync <= 1'b0;
            crt_horizontal_sync <= 1'b0;
        end else begin
            pixel_fetch <= next_fetch;
            if (next_fetch) begin
                pixel_out <= pixel_in;
            end else if (!(timing_gen_on && h_act_w && v_act_w)) begin
                pixel_out <= '0;
            end
            cursor_visible <= cur_show;
            text_visible <= txt_show;
            planar_vga_select <= cfg[`DTC_BIT_PLANAR];
            panel_display_enable <= next_enable;
            panel_vsync <= (v_sync && timing_gen_on) ^ panel_vsync_polarity;
            panel_hsync <= (h_sync && timing_gen_on) ^ panel_hsync_polarity;
            crt_vertical_sync <= crt_v_level;
            crt_horizontal_sync <= crt_h_level;
        end
    end
endmodule : dtc_timing

// File: sim/dtc_display_sink.sv
`timescale 1ns/1ps
module dtc_display_sink (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pixel_fetch,
    input wire logic panel_vsync,
    input wire logic polarity,
    output logic [7:0] pixel_in,
    output int frames
);
    logic seen;
    wire active = panel_vsync ^ polarity;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seen <= 1'b0;
            frames <= 0;
            pixel_in <= 8'h00;
        end else begin
            seen <= active;
            if (active && !seen) begin
                frames <= frames + 1;
            end
            // Junk between fetches, so a stale sample never looks right.
            pixel_in <= pixel_fetch ? pixel_in + 8'h01 : ~pixel_in;
        end
    end
endmodule : dtc_display_sink

// File: sim/dtc_timing_sva.sv
`timescale 1ns/1ps
`include "dtc_regs.svh"
module dtc_timing_sva #(
    parameter int PIX_WIDTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic pixel_fetch,
    input wire logic [PIX_WIDTH-1:0] pixel_in,
    input wire logic [PIX_WIDTH-1:0] pixel_out,
    input wire logic cursor_visible,
    input wire logic text_visible,
    input wire logic panel_display_enable,
    input wire logic panel_vsync,
    input wire logic panel_hsync,
    input wire logic crt_vertical_sync,
    input wire logic crt_horizontal_sync
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [31:0] cfg_q;
    logic [1:0] quiet;
    // Outputs lag a write by a short pipeline, so checks wait until it settles.
    wire steady = quiet == 2'h3;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= 32'h0;
            quiet <= 2'h0;
        end else if (wr && addr == 4'h0) begin
            cfg_q <= wdata & `DTC_CFG_WMASK;
            quiet <= 2'h0;
        end else if (!steady) begin
            quiet <= quiet + 2'h1;
        end
    end
    sequence s_cfg_read;
        rd && addr == 4'h0;
    endsequence
    a_idle_read: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("rdata not zero");
    a_unmapped_read: assert property (rd && addr[1:0] != 2'h0 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_pending_clear: assert property ( // clear
        s_cfg_read ##0 (steady && !cfg_q[6]) |=> !rdata[31]) else $error("pending stuck");
    a_ddc_clock: assert property ( // mux
        steady && !cfg_q[1] |-> crt_vertical_sync == cfg_q[4]) else $error("ddc mux");
    a_vsync_pol: assert property ( // vsync
        steady && cfg_q[1] |-> (panel_vsync ^ cfg_q[11]) == (crt_vertical_sync ^ cfg_q[9]))
        else $error("vsync polarity");
    a_hsync_pol: assert property ( // hsync
        steady && cfg_q[2] |-> (panel_hsync ^ cfg_q[10]) == (crt_horizontal_sync ^ cfg_q[8]))
        else $error("hsync polarity");
    a_panel_idle: assert property ( // idle
        steady && !cfg_q[5] |-> panel_vsync == cfg_q[11] && panel_hsync == cfg_q[10])
        else $error("panel idle level");
    a_gen_reset: assert property ( // held reset
        steady && !cfg_q[5] |-> !pixel_fetch && pixel_out == '0 && !panel_display_enable)
        else $error("dot logic not reset");
    a_blink_off: assert property ( // no blink
        steady && !cfg_q[7] |-> (cursor_visible && text_visible) [*2]) else $error("blinks");
    a_fetch_double: assert property ( // doubling
        $rose(pixel_fetch) && steady && cfg_q[15] |=> !pixel_fetch) else $error("no doubling");
    a_pixel_capture: assert property ( // capture
        pixel_fetch |-> pixel_out == $past(pixel_in)) else $error("pixel not captured");
endmodule : dtc_timing_sva
bind dtc_timing dtc_timing_sva #(.PIX_WIDTH(PIX_WIDTH)) u_sva (.*);

// File: sim/tb_display_timing_config_bits.sv
`timescale 1ns/1ps
`include "dtc_regs.svh"
module tb_display_timing_config_bits
    import dtc_pkg::*;
;
    logic clk, nrst, wr, rd, pixel_fetch, cursor_visible, text_visible, planar_vga_select, irq;
    logic panel_display_enable, panel_vsync, panel_hsync, crt_vertical_sync, crt_horizontal_sync;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, got, cfg;
    logic [7:0] pixel_in, pixel_out;
    int n_mismatch, checked, frames, a, b, k, nf0, ne0, nf1, ne1;
    dtc_timing u_dut (.*);
    dtc_display_sink u_sink (.clk(clk), .nrst(nrst), .pixel_fetch(pixel_fetch),
        .panel_vsync(panel_vsync), .polarity(cfg[11]), .pixel_in(pixel_in), .frames(frames));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a_i, input logic [31:0] d_i);
        @(posedge clk);
        addr <= a_i;
        wdata <= d_i;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a_i == 4'h0) cfg <= d_i & `DTC_CFG_WMASK;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a_i);
        @(posedge clk);
        addr <= a_i;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : rd_reg
    task automatic wait_frame();
        int f;
        f = frames;
        for (int i = 0; i < 5000 && frames == f; i++) @(posedge clk);
        if (frames == f) begin
            n_mismatch++;
            results();
        end
        repeat (4) @(posedge clk);
    endtask : wait_frame
    task automatic measure(input logic [31:0] v, output int nf, output int ne);
        int f;
        wr_reg(4'h0, v);
        // A polarity change can fake one frame edge, so count from the second.
        wait_frame();
        wait_frame();
        nf = 0;
        ne = 0;
        f = frames;
        for (int i = 0; i < 5000 && frames == f; i++) begin
            @(posedge clk);
            #1;
            nf += pixel_fetch;
            ne += panel_display_enable;
        end
        if (frames == f) begin
            n_mismatch++;
            results();
        end
    endtask : measure
    initial begin
        nrst = 1'b0;
        {wr, rd, addr, wdata, cfg} = '0;
        n_mismatch = 0;
        checked = 0;
        void'($urandom(98));
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(4'h0);
        chk(got, `DTC_CFG_RESET);
        rd_reg(4'h4);
        chk(got, `DTC_TIMING_RESET);
        rd_reg(4'h6);
        chk(got, 32'h0);
        wr_reg(4'h0, $urandom() & 32'hffff_ff9f);
        rd_reg(4'h0);
        chk(got, cfg);
        chk(planar_vga_select, cfg[13]);
        wr_reg(4'h4, 32'h3);
        wr_reg(4'h0, 32'h20);
        wr_reg(4'h4, $urandom());
        rd_reg(4'h4);
        chk(got, 32'h3);
        $display("registers done");
        for (k = 0; k < 4; k++) begin
            wr_reg(4'h0, k[0] ? 32'h10 : 32'h0);
            repeat (3) @(posedge clk);
            chk(crt_vertical_sync, k[0]);
        end
        $display("ddc done");
        for (a = 0; a < 2; a++) begin
            wr_reg(4'h0, a ? 32'hf00 : 32'h0);
            repeat (4) @(posedge clk);
            b = frames;
            wr_reg(4'h0, cfg | (a << 16) | 32'hae);
            for (k = 1; k <= 40; k++) begin
                wait_frame();
                chk(cursor_visible, ((frames - b) >> (3 + a)) % 2 == 0);
                chk(text_visible, ((frames - b) >> (4 + a)) % 2 == 0);
            end
        end
        $display("blink done");
        measure(32'h2e, nf0, ne0);
        measure(32'h802e, nf1, ne1);
        chk(nf1 * 2, nf0);
        measure(32'h102e, nf1, ne1);
        chk(ne1 > ne0, 32'h1);
        $display("doubling done");
        // Stop the generator and drain old events so the interrupt must be new.
        wr_reg(4'h0, 32'h0e);
        rd_reg(4'h8);
        wr_reg(4'hc, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 32'h0);
        wr_reg(4'h0, 32'h6e);
        wait_frame();
        chk(irq, 32'h1);
        rd_reg(4'h0);
        chk(got[31], 32'h1);
        wr_reg(4'hc, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 32'h0);
        wr_reg(4'hc, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 32'h1);
        wr_reg(4'h0, 32'h2e);
        repeat (3) @(posedge clk);
        rd_reg(4'h0);
        chk(got[31], 32'h0);
        wr_reg(4'h0, 32'h0e);
        rd_reg(4'h8);
        chk(got[0], 32'h1);
        rd_reg(4'h8);
        chk(got[0], 32'h0);
        chk(irq, 32'h0);
        $display("interrupt done");
        results();
    end
endmodule : tb_display_timing_config_bits
